// ---- hw/adis_input_select.sv ----
// Converter input select, reference select and buffered timer preload access
`timescale 1ns/10ps
`default_nettype none
module adis_input_select
(
	input  wire logic                   sys_clk_i,
	input  wire logic                   reset_i,
	input  wire adis_pkg::adis_bus_req_t bus_req_i,
	output logic [7:0]                  bus_rdata_o,
	input  wire logic                   second_chan_active_i,
	output logic [15:0]                 preload_o,
	output adis_pkg::adis_route_t       route_o,
	output logic                        ref_ext_sw_o,
	output logic                        ref_vdd_sw_o,
	output logic                        two_chan_auto_en_o,
	output adis_pkg::adis_pin_t         pin_o
);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		logic [7:0]           preload_low_buf;
		logic [7:0]           preload_low_reg;
		logic [7:0]           preload_high_reg;
		logic [3:0]           ext_channel_sel;
		logic [2:0]           input_kind_sel;
		logic [1:0]           ref_source_sel;
		logic                 two_chan_auto_en;
		logic [4:0]           first_chan_sel;
		logic [4:0]           second_chan_sel;
		logic [7:0]           pin_func_sel_low;
		logic [3:0]           pin_func_sel_high;
		logic [10:0]          pull_up;
		logic [10:0]          port_dir;
		logic [7:0]           rdata;
		adis_pkg::adis_route_t route;
		logic                 ref_ext_sw;
		logic                 ref_vdd_sw;
		adis_pkg::adis_pin_t  pin;
	} adis_state_t;

	adis_state_t state_reg;
	adis_state_t state_next;

	// ------------------------------------------------------------
	// Decoding helpers
	// ------------------------------------------------------------
	// One-hot channel switch; codes past the last input float
	function automatic logic [10:0] ext_decode(input logic [3:0] code);
		logic [10:0] sw;
		sw = 11'h000;
		// Loop keeps every index inside the switch vector
		for (int n = 0; n < adis_pkg::NUM_AN; n++)
		begin
			if (code == 4'(n) && code <= adis_pkg::LAST_EXT_CODE)
			begin
				sw[n] = 1'b1;
			end
		end
		return sw;
	endfunction

	// Manual and 1-channel mode routing
	function automatic adis_pkg::adis_route_t manual_route(
		input logic [2:0] kind,
		input logic [3:0] chan
	);
		adis_pkg::adis_route_t r;
		r = '0;
		// Channel field only counts for the external kinds
		case (kind)
			adis_pkg::KIND_BANDGAP:  r.bandgap  = 1'b1;
			adis_pkg::KIND_OPA_MAIN: r.opa_main = 1'b1;
			adis_pkg::KIND_OPA_AUX:  r.opa_aux  = 1'b1;
			adis_pkg::KIND_VSS:      r.vss      = 1'b1;
			default:                 r.ext = ext_decode(chan);
		endcase
		return r;
	endfunction

	// Two-channel mode routing for one channel selection
	function automatic adis_pkg::adis_route_t auto_route(
		input logic [4:0] sel
	);
		adis_pkg::adis_route_t r;
		logic [3:0]            sig;
		r = '0;
		sig = sel[3:0];
		// Manual fields play no part, so each channel stands alone
		if (sel[adis_pkg::CHAN_SRC_BIT])
		begin
			r.ext = ext_decode(sig);
		end
		else
		begin
			case (sig)
				adis_pkg::SIG_OPA_MAIN: r.opa_main = 1'b1;
				adis_pkg::SIG_OPA_AUX:  r.opa_aux  = 1'b1;
				adis_pkg::SIG_VSS:      r.vss      = 1'b1;
				default:                r.bandgap  = 1'b1;
			endcase
		end
		return r;
	endfunction

	// Reference select: only code 01 uses the supply
	// Codes 00, 10 and 11 all fall back to the pin
	function automatic logic ref_is_vdd(input logic [1:0] code);
		return code == adis_pkg::REF_VDD;
	endfunction

	// ------------------------------------------------------------
	// Pin sharing overrides
	// ------------------------------------------------------------
	// Done in hardware so software need not program the port first
	wire logic [10:0] func_analog;
	wire logic [10:0] pull_up_eff;
	wire logic [10:0] out_en_eff;

	assign func_analog = {state_reg.pin_func_sel_high[2:0],
		state_reg.pin_func_sel_low};

	// One slice per shared pin
	generate
		for (genvar n = 0; n < adis_pkg::NUM_AN; n++)
		begin : g_pin
			assign pull_up_eff[n] =
				state_reg.pull_up[n] & ~func_analog[n];
			assign out_en_eff[n] =
				state_reg.port_dir[n] & ~func_analog[n];
		end
	endgenerate

	// ------------------------------------------------------------
	// Bus request fields
	// ------------------------------------------------------------
	logic       wr;
	logic       rd;
	logic [7:0] addr;
	logic [7:0] wdata;

	assign wr = bus_req_i.wr;
	assign rd = bus_req_i.rd;
	assign addr = bus_req_i.addr;
	assign wdata = bus_req_i.wdata;

	// ------------------------------------------------------------
	// Next-state logic
	// ------------------------------------------------------------
	adis_pkg::adis_route_t sel_route;

	always_comb
	begin
		state_next = state_reg;
		// Read data fall back to zero outside the read slot
		state_next.rdata = adis_pkg::RESET_BYTE;

		// Register writes
		if (wr)
		begin
			if (addr == adis_pkg::ADDR_PRELOAD_LOW)
			begin
				state_next.preload_low_buf = wdata;
			end
			else if (addr == adis_pkg::ADDR_PRELOAD_HIGH)
			begin
				state_next.preload_high_reg = wdata;
				state_next.preload_low_reg = state_reg.preload_low_buf;
			end
			else if (addr == adis_pkg::ADDR_CONV_CTRL_A)
			begin
				state_next.ext_channel_sel = wdata[adis_pkg::EXT_CHAN_LSB +: 4];
			end
			else if (addr == adis_pkg::ADDR_CONV_CTRL_B)
			begin
				state_next.input_kind_sel =
					wdata[adis_pkg::INPUT_KIND_LSB +: 3];
				state_next.ref_source_sel = wdata[adis_pkg::REF_SRC_LSB +: 2];
			end
			else if (addr == adis_pkg::ADDR_FIRST_CHAN)
			begin
				state_next.two_chan_auto_en =
					wdata[adis_pkg::TWO_CHAN_EN_BIT];
				state_next.first_chan_sel = wdata[4:0];
			end
			else if (addr == adis_pkg::ADDR_SECOND_CHAN)
			begin
				state_next.second_chan_sel = wdata[4:0];
			end
			else if (addr == adis_pkg::ADDR_PIN_FUNC_LOW)
			begin
				state_next.pin_func_sel_low = wdata;
			end
			else if (addr == adis_pkg::ADDR_PIN_FUNC_HIGH)
			begin
				state_next.pin_func_sel_high = wdata[3:0];
			end
			else if (addr == adis_pkg::ADDR_PULL_UP_LOW)
			begin
				state_next.pull_up[7:0] = wdata;
			end
			else if (addr == adis_pkg::ADDR_PULL_UP_HIGH)
			begin
				state_next.pull_up[10:8] = wdata[2:0];
			end
			else if (addr == adis_pkg::ADDR_PORT_DIR_LOW)
			begin
				state_next.port_dir[7:0] = wdata;
			end
			else if (addr == adis_pkg::ADDR_PORT_DIR_HIGH)
			begin
				state_next.port_dir[10:8] = wdata[2:0];
			end
		end

		// Register reads; data stands in the following cycle only
		if (rd)
		begin
			if (addr == adis_pkg::ADDR_PRELOAD_LOW)
			begin
				state_next.rdata = state_reg.preload_low_buf;
			end
			else if (addr == adis_pkg::ADDR_PRELOAD_HIGH)
			begin
				state_next.rdata = state_reg.preload_high_reg;
				// Freezes the low byte so a later low read stays coherent
				state_next.preload_low_buf = state_reg.preload_low_reg;
			end
			else if (addr == adis_pkg::ADDR_CONV_CTRL_A)
			begin
				state_next.rdata = {4'h0, state_reg.ext_channel_sel};
			end
			else if (addr == adis_pkg::ADDR_CONV_CTRL_B)
			begin
				state_next.rdata = {3'h0, state_reg.ref_source_sel,
					state_reg.input_kind_sel};
			end
			else if (addr == adis_pkg::ADDR_FIRST_CHAN)
			begin
				state_next.rdata = {2'h0, state_reg.two_chan_auto_en,
					state_reg.first_chan_sel};
			end
			else if (addr == adis_pkg::ADDR_SECOND_CHAN)
			begin
				state_next.rdata = {3'h0, state_reg.second_chan_sel};
			end
			else if (addr == adis_pkg::ADDR_PIN_FUNC_LOW)
			begin
				state_next.rdata = state_reg.pin_func_sel_low;
			end
			else if (addr == adis_pkg::ADDR_PIN_FUNC_HIGH)
			begin
				state_next.rdata = {4'h0, state_reg.pin_func_sel_high};
			end
			else if (addr == adis_pkg::ADDR_PULL_UP_LOW)
			begin
				state_next.rdata = state_reg.pull_up[7:0];
			end
			else if (addr == adis_pkg::ADDR_PULL_UP_HIGH)
			begin
				state_next.rdata = {5'h00, state_reg.pull_up[10:8]};
			end
			else if (addr == adis_pkg::ADDR_PORT_DIR_LOW)
			begin
				state_next.rdata = state_reg.port_dir[7:0];
			end
			else if (addr == adis_pkg::ADDR_PORT_DIR_HIGH)
			begin
				state_next.rdata = {5'h00, state_reg.port_dir[10:8]};
			end
			else if (addr == adis_pkg::ADDR_ROUTE_STATUS)
			begin
				// Live routing: ref switch, internal sources, any external
				state_next.rdata = {2'h0, state_reg.ref_vdd_sw,
					state_reg.route.bandgap, state_reg.route.opa_main,
					state_reg.route.opa_aux, state_reg.route.vss,
					|state_reg.route.ext};
			end
		end

		// Converter input multiplexer
		if (state_reg.two_chan_auto_en)
		begin
			if (second_chan_active_i)
			begin
				sel_route = auto_route(state_reg.second_chan_sel);
			end
			else
			begin
				sel_route = auto_route(state_reg.first_chan_sel);
			end
		end
		else
		begin
			sel_route = manual_route(state_reg.input_kind_sel,
				state_reg.ext_channel_sel);
		end
		// Internal picks carry an all-zero external vector by construction
		if (sel_route.bandgap | sel_route.opa_main | sel_route.opa_aux |
			sel_route.vss)
		begin
			sel_route.ext = 11'h000;
		end
		state_next.route = sel_route;

		// Reference switches; never both closed
		state_next.ref_vdd_sw = ref_is_vdd(state_reg.ref_source_sel);
		state_next.ref_ext_sw = !ref_is_vdd(state_reg.ref_source_sel);

		// Pin sharing overrides
		state_next.pin.analog = func_analog;
		state_next.pin.pull_up = pull_up_eff;
		state_next.pin.out_en = out_en_eff;
		// External reference relies on software freeing the pin first
		state_next.pin.ref_pin_analog =
			state_reg.pin_func_sel_high[adis_pkg::REF_PIN_FUNC_BIT];
	end

	// ------------------------------------------------------------
	// State register
	// ------------------------------------------------------------
	// Preload powers up undefined; cleared here so reset is repeatable
	always_ff @(posedge sys_clk_i)
	begin
		if (reset_i)
		begin
			state_reg <= '0;
			state_reg.ref_ext_sw <= 1'b1;
		end
		else
		begin
			state_reg <= state_next;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign bus_rdata_o = state_reg.rdata;
	assign preload_o = {state_reg.preload_high_reg, state_reg.preload_low_reg};
	assign route_o = state_reg.route;
	assign ref_ext_sw_o = state_reg.ref_ext_sw;
	assign ref_vdd_sw_o = state_reg.ref_vdd_sw;
	assign two_chan_auto_en_o = state_reg.two_chan_auto_en;
	assign pin_o = state_reg.pin;

endmodule
`default_nettype wire

// ---- hw/adis_pkg.sv ----
// Package: register map, field layout and types of the converter input select
`default_nettype none
package adis_pkg;

	// ------------------------------------------------------------
	// Register addresses
	// ------------------------------------------------------------
	localparam logic [7:0] ADDR_PRELOAD_LOW   = 8'h00;
	localparam logic [7:0] ADDR_PRELOAD_HIGH  = 8'h01;
	localparam logic [7:0] ADDR_CONV_CTRL_A   = 8'h02;
	localparam logic [7:0] ADDR_CONV_CTRL_B   = 8'h03;
	localparam logic [7:0] ADDR_FIRST_CHAN    = 8'h04;
	localparam logic [7:0] ADDR_SECOND_CHAN   = 8'h05;
	localparam logic [7:0] ADDR_PIN_FUNC_LOW  = 8'h06;
	localparam logic [7:0] ADDR_PIN_FUNC_HIGH = 8'h07;
	localparam logic [7:0] ADDR_PULL_UP_LOW   = 8'h08;
	localparam logic [7:0] ADDR_PULL_UP_HIGH  = 8'h09;
	localparam logic [7:0] ADDR_PORT_DIR_LOW  = 8'h0a;
	localparam logic [7:0] ADDR_PORT_DIR_HIGH = 8'h0b;
	localparam logic [7:0] ADDR_ROUTE_STATUS  = 8'h0c;

	// ------------------------------------------------------------
	// Field positions and widths
	// ------------------------------------------------------------
	localparam int EXT_CHAN_LSB     = 0;
	localparam int INPUT_KIND_LSB   = 0;
	localparam int REF_SRC_LSB      = 3;
	localparam int CHAN_SIG_LSB     = 0;
	localparam int CHAN_SRC_BIT     = 4;
	localparam int TWO_CHAN_EN_BIT  = 5;
	localparam int NUM_AN           = 11;
	localparam int REF_PIN_FUNC_BIT = 3;

	// ------------------------------------------------------------
	// Codes and reset values
	// ------------------------------------------------------------
	localparam logic [3:0] LAST_EXT_CODE = 4'ha;
	localparam logic [2:0] KIND_EXT      = 3'h0;
	localparam logic [2:0] KIND_BANDGAP  = 3'h1;
	localparam logic [2:0] KIND_OPA_MAIN = 3'h2;
	localparam logic [2:0] KIND_OPA_AUX  = 3'h3;
	localparam logic [2:0] KIND_VSS      = 3'h4;
	localparam logic [3:0] SIG_OPA_MAIN  = 4'h1;
	localparam logic [3:0] SIG_OPA_AUX   = 4'h2;
	localparam logic [3:0] SIG_VSS       = 4'h3;
	localparam logic [1:0] REF_VDD       = 2'h1;
	localparam logic [7:0] RESET_BYTE    = 8'h00;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} adis_bus_req_t;

	typedef struct packed {
		logic [10:0] ext;
		logic        bandgap;
		logic        opa_main;
		logic        opa_aux;
		logic        vss;
	} adis_route_t;

	typedef struct packed {
		logic [10:0] analog;
		logic [10:0] pull_up;
		logic [10:0] out_en;
		logic        ref_pin_analog;
	} adis_pin_t;

endpackage
`default_nettype wire

// ---- tb/adis_seq_model.sv ----
// Partner: converter sequencer stand-in raising the second-channel flag
`timescale 1ns/10ps
`default_nettype none
module adis_seq_model
(
	input  wire logic sys_clk_i,
	input  wire logic reset_i,
	input  wire logic want_i,
	output logic      second_chan_active_o
);
	// Registered, so the flag only ever moves on clock edges
	always_ff @(posedge sys_clk_i)
		second_chan_active_o <= reset_i ? 1'b0 : want_i;
endmodule
`default_nettype wire

// ---- tb/adis_input_select_asserts.sv ----
// Checker: port-level properties of the converter input select
`timescale 1ns/10ps
`default_nettype none
module adis_input_select_asserts
(
	input wire logic                    sys_clk_i,
	input wire logic                    reset_i,
	input wire adis_pkg::adis_bus_req_t bus_req_i,
	input wire logic [7:0]              bus_rdata_o,
	input wire logic                    second_chan_active_i,
	input wire logic [15:0]             preload_o,
	input wire adis_pkg::adis_route_t   route_o,
	input wire logic                    ref_ext_sw_o,
	input wire logic                    ref_vdd_sw_o,
	input wire logic                    two_chan_auto_en_o,
	input wire adis_pkg::adis_pin_t     pin_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (reset_i);
	logic [7:0] a;
	logic       wr;
	logic       rd;
	logic       inner;
	assign a = bus_req_i.addr;
	assign wr = bus_req_i.wr;
	assign rd = bus_req_i.rd;
	assign inner = route_o.bandgap | route_o.opa_main | route_o.opa_aux
		| route_o.vss;
	a_low_write_held: assert property (wr && a == 8'h00 |=>
		$stable(preload_o)) else $error("preload moved on low write");
	a_high_write_load: assert property (wr && a == 8'h01 |=>
		preload_o[15:8] == $past(bus_req_i.wdata))
		else $error("high byte not loaded");
	a_high_read_data: assert property (rd && a == 8'h01 |=>
		bus_rdata_o == $past(preload_o[15:8]))
		else $error("high byte read wrong");
	a_read_idle_zero: assert property (!$past(rd) |-> bus_rdata_o == 8'h00)
		else $error("read data outside read slot");
	a_one_route: assert property ($onehot0(route_o))
		else $error("more than one source routed");
	a_internal_isolates: assert property (inner |-> route_o.ext == 11'h000)
		else $error("external joined to internal");
	a_ref_exclusive: assert property (ref_ext_sw_o != ref_vdd_sw_o)
		else $error("reference switches not exclusive");
	a_pull_up_off: assert property ((pin_o.pull_up & pin_o.analog) == 11'h0)
		else $error("pull-up on analog pin");
	a_dir_override: assert property ((pin_o.out_en & pin_o.analog) == 11'h0)
		else $error("driver on analog pin");
	a_two_chan_en: assert property (wr && a == 8'h04 |=>
		two_chan_auto_en_o == $past(bus_req_i.wdata[5]))
		else $error("two-channel enable wrong");
endmodule
bind adis_input_select adis_input_select_asserts u_chk (.sys_clk_i,
	.reset_i, .bus_req_i, .bus_rdata_o, .second_chan_active_i, .preload_o,
	.route_o, .ref_ext_sw_o, .ref_vdd_sw_o, .two_chan_auto_en_o, .pin_o);
`default_nettype wire

// ---- tb/adis_input_select_tb.sv ----
// Testbench: preload buffering, reference, route and pin sharing
`timescale 1ns/10ps
`default_nettype none
module adis_input_select_tb;
	logic                    sys_clk_i = 1'b0;
	logic                    reset_i = 1'b1;
	adis_pkg::adis_bus_req_t req = '0;
	logic [7:0]              rdata;
	logic                    want2 = 1'b0;
	logic                    sec;
	logic [15:0]             preload;
	adis_pkg::adis_route_t   route;
	logic                    ref_ext;
	logic                    ref_vdd;
	logic                    two_en;
	adis_pkg::adis_pin_t     pin;
	int                      fails = 0;
	int                      checks = 0;
	logic [7:0]              exp_q[$];
	logic                    rd_d = 1'b0;
	logic [7:0]              lo;
	logic [7:0]              hi;
	logic [7:0]              a;
	logic [7:0]              b;
	logic [10:0]             an;

	always #5 sys_clk_i = ~sys_clk_i;

	adis_input_select DUT (.sys_clk_i, .reset_i, .bus_req_i(req),
		.bus_rdata_o(rdata), .second_chan_active_i(sec),
		.preload_o(preload), .route_o(route), .ref_ext_sw_o(ref_ext),
		.ref_vdd_sw_o(ref_vdd), .two_chan_auto_en_o(two_en), .pin_o(pin));
	adis_seq_model u_seq (.sys_clk_i, .reset_i, .want_i(want2),
		.second_chan_active_o(sec));

	task automatic chk(input string n, input logic [15:0] s,
		input logic [15:0] e);
		checks++;
		if (s !== e)
		begin
			fails++;
			$display("wrong value %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic bus(input logic [7:0] ad, input logic [7:0] d,
		input logic w);
		@(posedge sys_clk_i);
		req <= '{ad, d, w, ~w};
	endtask
	task automatic rd(input logic [7:0] ad, input logic [7:0] e);
		exp_q.push_back(e);
		bus(ad, 8'h00, 1'b0);
	endtask
	// Derived outputs trail a write by two edges
	task automatic settle();
		@(posedge sys_clk_i);
		req <= '0;
		repeat (3) @(posedge sys_clk_i);
		#1;
	endtask
	task automatic results();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	function automatic adis_pkg::adis_route_t er(input logic x,
		input logic [3:0] s, input logic [2:0] k);
		er = '0;
		if (x)
			er.ext = (s <= 4'ha) ? 11'h001 << s : 11'h000;
		else
			case (k)
				3'h2: er.opa_main = 1'b1;
				3'h3: er.opa_aux = 1'b1;
				3'h4: er.vss = 1'b1;
				default: er.bandgap = 1'b1;
			endcase
	endfunction
	function automatic logic [15:0] ec(input logic [4:0] s);
		ec = {1'b0, er(s[4], s[3:0],
			(s[3:0] >= 4'h1 && s[3:0] <= 4'h3) ? 3'(s[3:0] + 4'h1) : 3'h1)};
	endfunction

	// Read data stand only in the cycle after the strobe
	always @(posedge sys_clk_i)
	begin
		if (rd_d)
			chk("rdata", {8'h00, rdata}, {8'h00, exp_q.pop_front()});
		rd_d = req.rd;
	end

	initial
	begin
		#200000;
		fails++;
		results();
	end

	initial
	begin
		void'($urandom(32'h4223));
		repeat (6) @(posedge sys_clk_i);
		reset_i <= 1'b0;
		for (int i = 0; i < 13; i++)
			rd(i[7:0], (i == 12) ? 8'h01 : 8'h00);
		rd(8'h20, 8'h00);
		settle();
		$display("test reset done");
		lo = 8'($urandom());
		hi = 8'($urandom());
		bus(8'h00, lo, 1'b1);
		settle();
		chk("preload", preload, 16'h0000);
		bus(8'h01, hi, 1'b1);
		bus(8'h00, ~lo, 1'b1);
		settle();
		chk("preload", preload, {hi, lo});
		rd(8'h01, hi);
		rd(8'h00, lo);
		settle();
		$display("test preload done");
		bus(8'h07, 8'h08, 1'b1);
		for (int k = 0; k < 4; k++)
		begin
			bus(8'h03, {3'h0, k[1:0], 3'h0}, 1'b1);
			settle();
			chk("ref_vdd", {15'h0, ref_vdd}, {15'h0, k == 1});
			chk("ref_ext", {15'h0, ref_ext}, {15'h0, k != 1});
			chk("ref_pin", {15'h0, pin.ref_pin_analog}, 16'h1);
		end
		$display("test reference done");
		for (int i = 0; i < 128; i++)
		begin
			bus(8'h02, {4'h0, i[3:0]}, 1'b1);
			bus(8'h03, {5'h0, i[6:4]}, 1'b1);
			settle();
			chk("route", {1'b0, route}, {1'b0, er(i[6:4] == 3'h0
				|| i[6:4] > 3'h4, i[3:0], i[6:4])});
		end
		$display("test manual route done");
		for (int i = 0; i < 32; i++)
		begin
			b = 8'($urandom()) & 8'h1f;
			bus(8'h04, {3'h1, i[4:0]}, 1'b1);
			bus(8'h05, b, 1'b1);
			settle();
			chk("route1", {1'b0, route}, ec(i[4:0]));
			chk("two_en", {15'h0, two_en}, 16'h1);
			want2 <= 1'b1;
			settle();
			chk("route2", {1'b0, route}, ec(b[4:0]));
			want2 <= 1'b0;
		end
		bus(8'h04, 8'h1f, 1'b1);
		settle();
		chk("two_en", {15'h0, two_en}, 16'h0);
		chk("route", {1'b0, route}, 16'h0000);
		$display("test two channel done");
		a = 8'($urandom());
		b = 8'($urandom());
		an = {b[2:0], a};
		bus(8'h06, a, 1'b1);
		bus(8'h07, {5'h01, b[2:0]}, 1'b1);
		bus(8'h08, 8'hff, 1'b1);
		bus(8'h09, 8'h07, 1'b1);
		bus(8'h0a, 8'hff, 1'b1);
		bus(8'h0b, 8'h07, 1'b1);
		settle();
		chk("analog", {5'h0, pin.analog}, {5'h0, an});
		chk("pull_up", {5'h0, pin.pull_up}, {5'h0, ~an});
		chk("out_en", {5'h0, pin.out_en}, {5'h0, ~an});
		rd(8'h06, a);
		settle();
		$display("test pins done");
		results();
	end
endmodule
`default_nettype wire
